/* hw/low_power_uart_core.sv */
// Serial transmitter and receiver with APB registers, slow-clock baud and auto-baud
`timescale 1ns/100ps

module low_power_uart_core #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic              slow_timer_clock,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_line,
  output logic                   tx_line,
  output logic                   rx_error_event
);

  localparam int TXC = 0;
  localparam int RXC = 1;

  function automatic logic [3:0] data_bits(input logic [2:0] code);
    data_bits = (code > 3'h4) ? 4'h9 : 4'(code) + 4'h5;
  endfunction

  function automatic logic [2:0] stop_halves(input logic [1:0] len, input logic slow);
    stop_halves = slow ? (len[1] ? 3'h4 : 3'h2) : 3'(len) + 3'h1;
  endfunction

  function automatic logic par_bit(input logic [1:0] md, input logic [8:0] d);
    case (uart_core_pkg::parity_mode_t'(md))
      uart_core_pkg::PAR_ODD:  par_bit = ~(^d);
      uart_core_pkg::PAR_EVEN: par_bit = ^d;
      uart_core_pkg::PAR_ONE:  par_bit = 1'b1;
      default:                 par_bit = 1'b0;
    endcase
  endfunction

  logic [31:0] cfg_r;
  logic [31:0] mode_r;
  logic [15:0] rx_div_r;
  logic [15:0] tx_div_r;
  logic        err_ie_r;
  logic        ab_en_r;
  logic        ir_en_r;
  logic        perr_r;
  logic        ferr_r;
  logic        ovr_r;
  logic        tx_done_r;
  logic [31:0] prdata_r;
  logic [1:0]  mdiv_r;
  logic        slow_cur_r;
  logic        slow_prev_r;
  logic [8:0]  tx_hold_r;
  logic        tx_full_r;
  logic [8:0]  tx_shift_r;
  logic        tx_par_r;
  logic [3:0]  tx_bit_r;
  logic [2:0]  tx_half_r;
  logic        tx_line_r;
  logic [8:0]  rx_data_r;
  logic        rx_valid_r;
  logic [8:0]  rx_shift_r;
  logic [3:0]  rx_bit_r;
  logic [2:0]  rx_half_r;
  logic        rx_prev_r;
  logic [23:0] ab_cnt_r;
  logic [3:0]  ab_edges_r;
  uart_core_pkg::tx_state_t tx_state_r;
  uart_core_pkg::tx_state_t tx_next;
  uart_core_pkg::rx_state_t rx_state_r;
  uart_core_pkg::rx_state_t rx_next;
  logic        tx_line_nxt;

  // Bus decode
  wire access   = psel & penable;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire [7:0] a8 = 8'(paddr);
  wire hit_cfg  = (a8 == uart_core_pkg::OFF_CONFIG);
  wire hit_mode = (a8 == uart_core_pkg::OFF_MODE);
  wire hit_ctl  = (a8 == uart_core_pkg::OFF_CONTROL);
  wire hit_baud = (a8 == uart_core_pkg::OFF_BAUD);
  wire hit_data = (a8 == uart_core_pkg::OFF_DATA);
  wire mapped   = hit_cfg | hit_mode | hit_ctl | hit_baud | hit_data;
  wire wr_ok    = clk_en & access & pwrite & mapped;
  wire pop      = clk_en & access & ~pwrite & hit_data;
  wire push     = wr_ok & hit_data & ~tx_full_r;

  // Configuration fields
  wire [15:0] tcfg = cfg_r[15:0];
  wire [15:0] rcfg = cfg_r[uart_core_pkg::CFG_RX_BASE +: 16];
  wire tx_start_en = tcfg[uart_core_pkg::CFG_START];
  wire tx_par_en   = tcfg[uart_core_pkg::CFG_PAR_EN];
  wire tx_stop_en  = tcfg[uart_core_pkg::CFG_STOP_EN];
  wire rx_start_en = rcfg[uart_core_pkg::CFG_START];
  wire rx_par_en   = rcfg[uart_core_pkg::CFG_PAR_EN];
  wire rx_stop_en  = rcfg[uart_core_pkg::CFG_STOP_EN];
  wire [1:0] tx_par_md = tcfg[uart_core_pkg::CFG_PAR_MD +: 2];
  wire [1:0] rx_par_md = rcfg[uart_core_pkg::CFG_PAR_MD +: 2];
  wire [3:0] tx_bits   = data_bits(tcfg[uart_core_pkg::CFG_LEN +: 3]);
  wire [3:0] rx_bits   = data_bits(rcfg[uart_core_pkg::CFG_LEN +: 3]);
  wire [8:0] tx_mask   = ~(9'h1ff << tx_bits);
  wire [8:0] rx_mask   = ~(9'h1ff << rx_bits);

  wire full_slow  = mode_r[uart_core_pkg::MD_FULL_SLOW];
  wire slow_mode  = full_slow | mode_r[uart_core_pkg::MD_BAUD_SLOW];
  wire force_clk  = mode_r[uart_core_pkg::MD_FORCE];
  wire [1:0] cdiv = mode_r[uart_core_pkg::MD_CLK_DIV +: 2];

  // Module clock tick from the bus clock
  wire mod_tick = (cdiv == uart_core_pkg::DIV_BY1) ? 1'b1 :
                  (cdiv == uart_core_pkg::DIV_BY2) ? mdiv_r[0] : (mdiv_r == 2'h3);

  // Slow clock: every cycle when the bus runs from it, else its rising edge
  wire slow_tick = full_slow ? 1'b1 : (slow_cur_r & ~slow_prev_r);

  // Channel clock source: an event with auto switch hands the channel to the bus clock
  wire rx_pending = rx_valid_r | perr_r | ferr_r | ovr_r;
  wire [1:0] ch_slow;
  assign ch_slow[TXC] = slow_mode & ~(mode_r[uart_core_pkg::MD_TX_SW] & tx_done_r);
  assign ch_slow[RXC] = slow_mode & ~(mode_r[uart_core_pkg::MD_RX_SW] & rx_pending);

  wire [15:0] ch_div [2];
  assign ch_div[TXC] = tx_div_r;
  assign ch_div[RXC] = rx_div_r;
  wire [1:0] ch_run;
  assign ch_run[TXC] = force_clk | (tx_state_r != uart_core_pkg::TX_IDLE);
  assign ch_run[RXC] = force_clk | (rx_state_r != uart_core_pkg::RX_IDLE);
  wire [1:0] ch_restart;
  wire [1:0] half_tick;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_baud
      logic [15:0] cnt_r;
      logic [15:0] acc_r;
      logic [15:0] inc;
      wire  [15:0] lim     = (ch_div[g] == 16'h0) ? 16'h1 : ch_div[g];
      wire  [15:0] cnt_inc = cnt_r + 16'h1;
      wire         cnt_hit = (cnt_inc >= lim);
      wire  [16:0] acc_sum = {1'b0, acc_r} + {1'b0, inc};
      wire         acc_hit = (acc_sum >= uart_core_pkg::SLOW_CLOCK_HZ);
      always_comb begin
        unique case (ch_div[g][1:0])
          uart_core_pkg::SEL_1200: inc = uart_core_pkg::HALF_INC_1200;
          uart_core_pkg::SEL_9600: inc = uart_core_pkg::HALF_INC_9600;
          uart_core_pkg::SEL_4800: inc = uart_core_pkg::HALF_INC_4800;
          default:                 inc = uart_core_pkg::HALF_INC_2400;
        endcase
      end
      // Half-bit tick: divisor module clocks, or phase wrap of the gated slow clock
      assign half_tick[g] = ch_slow[g] ? (slow_tick & ch_run[g] & acc_hit)
                                       : (mod_tick & cnt_hit);
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          cnt_r <= 16'h0;
          acc_r <= 16'h0;
        end else if (clk_en) begin
          if (ch_restart[g]) begin
            cnt_r <= 16'h0;
            acc_r <= 16'h0;
          end else begin
            if (mod_tick)
              cnt_r <= cnt_hit ? 16'h0 : cnt_inc;
            if (slow_tick & ch_run[g])
              acc_r <= acc_hit ? 16'(acc_sum - uart_core_pkg::SLOW_CLOCK_HZ) : acc_sum[15:0];
          end
        end
      end
    end
  endgenerate

  // Transmitter sequencing
  wire tx_last = (tx_bit_r == tx_bits - 4'h1);
  wire tx_step = (tx_state_r == uart_core_pkg::TX_IDLE) ? tx_full_r
                                                       : (half_tick[TXC] & (tx_half_r == 3'h1));
  wire tx_done_evt = tx_step & (tx_state_r != uart_core_pkg::TX_IDLE) &
                     (tx_next == uart_core_pkg::TX_IDLE);
  assign ch_restart[TXC] = tx_step & (tx_state_r == uart_core_pkg::TX_IDLE);

  always_comb begin
    tx_next = tx_state_r;
    unique case (tx_state_r)
      uart_core_pkg::TX_IDLE:
        tx_next = tx_start_en ? uart_core_pkg::TX_START : uart_core_pkg::TX_DATA;
      uart_core_pkg::TX_START: tx_next = uart_core_pkg::TX_DATA;
      uart_core_pkg::TX_DATA: begin
        if (tx_last)
          tx_next = tx_par_en ? uart_core_pkg::TX_PAR :
                    tx_stop_en ? uart_core_pkg::TX_STOP : uart_core_pkg::TX_IDLE;
      end
      uart_core_pkg::TX_PAR:
        tx_next = tx_stop_en ? uart_core_pkg::TX_STOP : uart_core_pkg::TX_IDLE;
      uart_core_pkg::TX_STOP: tx_next = uart_core_pkg::TX_IDLE;
    endcase
  end

  always_comb begin
    unique case (tx_next)
      uart_core_pkg::TX_START: tx_line_nxt = 1'b0;
      uart_core_pkg::TX_DATA: begin
        if (tx_state_r == uart_core_pkg::TX_IDLE)
          tx_line_nxt = tx_hold_r[0];
        else if (tx_state_r == uart_core_pkg::TX_DATA)
          tx_line_nxt = tx_shift_r[1];
        else
          tx_line_nxt = tx_shift_r[0];
      end
      uart_core_pkg::TX_PAR: tx_line_nxt = tx_par_r;
      default:               tx_line_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_state_r <= uart_core_pkg::TX_IDLE;
      tx_line_r  <= 1'b1;
      tx_shift_r <= 9'h0;
      tx_par_r   <= 1'b0;
      tx_bit_r   <= 4'h0;
      tx_half_r  <= 3'h2;
    end else if (clk_en) begin
      if (tx_step) begin
        tx_state_r <= tx_next;
        tx_line_r  <= tx_line_nxt;
        tx_half_r  <= (tx_next == uart_core_pkg::TX_STOP) ?
                      stop_halves(tcfg[uart_core_pkg::CFG_STOP_LEN +: 2], ch_slow[TXC]) : 3'h2;
        if (tx_state_r == uart_core_pkg::TX_IDLE) begin
          tx_shift_r <= tx_hold_r & tx_mask;
          tx_par_r   <= par_bit(tx_par_md, tx_hold_r & tx_mask);
          tx_bit_r   <= 4'h0;
        end else if (tx_state_r == uart_core_pkg::TX_DATA && tx_next == uart_core_pkg::TX_DATA) begin
          tx_shift_r <= tx_shift_r >> 1;
          tx_bit_r   <= tx_bit_r + 4'h1;
        end
      end else if (half_tick[TXC] && tx_state_r != uart_core_pkg::TX_IDLE) begin
        tx_half_r <= tx_half_r - 3'h1;
      end
    end
  end

  // Receiver sequencing
  wire rx_edge   = (rx_line != rx_prev_r);
  wire rx_fall   = rx_prev_r & ~rx_line;
  wire rx_ir     = ir_en_r & ~slow_mode;
  wire ab_active = ab_en_r & ~slow_mode & rx_start_en;
  wire rx_idle   = (rx_state_r == uart_core_pkg::RX_IDLE);
  wire rx_detect = (rx_state_r == uart_core_pkg::RX_DETECT);
  wire rx_sample = ~rx_idle & ~rx_detect & half_tick[RXC] & (rx_half_r == 3'h1);
  wire rx_trig   = rx_start_en ? rx_fall : rx_edge;
  wire ab_load   = rx_detect & rx_edge & (ab_edges_r == uart_core_pkg::AB_LAST_EDGE);
  wire rx_step   = rx_idle ? rx_trig : (rx_detect ? ab_load : rx_sample);
  wire rx_last   = (rx_bit_r == rx_bits - 4'h1);
  wire rx_finish = rx_sample & (rx_next == uart_core_pkg::RX_IDLE) &
                   (rx_state_r != uart_core_pkg::RX_START);
  wire [8:0]  rx_word = rx_shift_r & rx_mask;
  wire [23:0] ab_quot = rx_ir ? (ab_cnt_r >> uart_core_pkg::AB_SHIFT_IR)
                              : (ab_cnt_r >> uart_core_pkg::AB_SHIFT_NORMAL);
  wire ab_ovf   = (|ab_quot[23:16]) | (&ab_cnt_r);
  wire perr_evt = rx_sample & (rx_state_r == uart_core_pkg::RX_PAR) &
                  (rx_line != par_bit(rx_par_md, rx_word));
  wire ferr_evt = (rx_sample & (rx_state_r == uart_core_pkg::RX_STOP) & ~rx_line) |
                  (ab_load & ab_ovf);
  wire ovr_evt  = rx_finish & rx_valid_r & ~pop;
  assign ch_restart[RXC] = rx_step & (rx_idle | rx_detect);

  always_comb begin
    rx_next = rx_state_r;
    unique case (rx_state_r)
      uart_core_pkg::RX_IDLE:
        rx_next = ab_active ? uart_core_pkg::RX_DETECT :
                  rx_start_en ? uart_core_pkg::RX_START : uart_core_pkg::RX_DATA;
      uart_core_pkg::RX_DETECT: rx_next = uart_core_pkg::RX_DATA;
      uart_core_pkg::RX_START:
        rx_next = rx_line ? uart_core_pkg::RX_IDLE : uart_core_pkg::RX_DATA;
      uart_core_pkg::RX_DATA: begin
        if (rx_last)
          rx_next = rx_par_en ? uart_core_pkg::RX_PAR :
                    rx_stop_en ? uart_core_pkg::RX_STOP : uart_core_pkg::RX_IDLE;
      end
      uart_core_pkg::RX_PAR:
        rx_next = rx_stop_en ? uart_core_pkg::RX_STOP : uart_core_pkg::RX_IDLE;
      uart_core_pkg::RX_STOP: rx_next = uart_core_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_state_r <= uart_core_pkg::RX_IDLE;
      rx_shift_r <= 9'h0;
      rx_bit_r   <= 4'h0;
      rx_half_r  <= 3'h1;
      rx_prev_r  <= 1'b1;
      ab_cnt_r   <= 24'h0;
      ab_edges_r <= 4'h0;
    end else if (clk_en) begin
      rx_prev_r <= rx_line;
      if (rx_step) begin
        rx_state_r <= rx_next;
        if (rx_idle || rx_detect)
          rx_half_r <= 3'h1;
        else if (rx_next == uart_core_pkg::RX_STOP)
          rx_half_r <= (stop_halves(rcfg[uart_core_pkg::CFG_STOP_LEN +: 2], ch_slow[RXC]) == 3'h1) ?
                       3'h1 : 3'h2;
        else
          rx_half_r <= 3'h2;
        if (rx_idle) begin
          rx_bit_r   <= 4'h0;
          // The start edge cycle counts, so the span covers both leading edges
          ab_cnt_r   <= 24'(mod_tick);
          ab_edges_r <= 4'h0;
        end else if (rx_detect) begin
          rx_shift_r[6] <= rx_prev_r;
          rx_bit_r      <= uart_core_pkg::AB_FIRST_BIT;
        end else if (rx_state_r == uart_core_pkg::RX_DATA) begin
          rx_shift_r[rx_bit_r] <= rx_line;
          rx_bit_r             <= rx_bit_r + 4'h1;
        end
      end else if (rx_detect) begin
        if (mod_tick && !(&ab_cnt_r))
          ab_cnt_r <= ab_cnt_r + 24'h1;
        if (rx_edge) begin
          ab_edges_r <= ab_edges_r + 4'h1;
          if (ab_edges_r != 4'h0)
            rx_shift_r[ab_edges_r - 4'h1] <= rx_prev_r;
        end
      end else if (half_tick[RXC] && !rx_idle) begin
        rx_half_r <= rx_half_r - 3'h1;
      end
    end
  end

  // Register file, holding words and sticky flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_r       <= uart_core_pkg::CONFIG_RESET;
      mode_r      <= uart_core_pkg::MODE_RESET;
      rx_div_r    <= uart_core_pkg::BAUD_RESET;
      tx_div_r    <= uart_core_pkg::BAUD_RESET;
      err_ie_r    <= 1'b0;
      ab_en_r     <= 1'b0;
      ir_en_r     <= 1'b0;
      perr_r      <= 1'b0;
      ferr_r      <= 1'b0;
      ovr_r       <= 1'b0;
      tx_done_r   <= 1'b0;
      tx_hold_r   <= 9'h0;
      tx_full_r   <= 1'b0;
      rx_data_r   <= 9'h0;
      rx_valid_r  <= 1'b0;
      mdiv_r      <= 2'h0;
      slow_cur_r  <= 1'b0;
      slow_prev_r <= 1'b0;
    end else if (clk_en) begin
      mdiv_r      <= mdiv_r + 2'h1;
      slow_cur_r  <= slow_timer_clock;
      slow_prev_r <= slow_cur_r;
      if (wr_ok && hit_cfg)
        cfg_r <= pwdata & uart_core_pkg::CONFIG_MASK;
      if (wr_ok && hit_mode)
        mode_r <= pwdata & uart_core_pkg::MODE_MASK;
      if (wr_ok && hit_baud)
        tx_div_r <= pwdata[uart_core_pkg::BAUD_TX_POS +: 16];
      if (ab_load)
        rx_div_r <= ab_quot[15:0];
      else if (wr_ok && hit_baud)
        rx_div_r <= pwdata[15:0];
      if (ab_load)
        ab_en_r <= 1'b0;
      else if (wr_ok && hit_ctl)
        ab_en_r <= pwdata[uart_core_pkg::CTL_AB_EN];
      if (wr_ok && hit_ctl) begin
        err_ie_r <= pwdata[uart_core_pkg::CTL_ERR_IE];
        ir_en_r  <= pwdata[uart_core_pkg::CTL_IR_EN];
      end
      perr_r <= perr_evt | (perr_r & ~(wr_ok & hit_ctl & pwdata[uart_core_pkg::CTL_PERR]));
      ferr_r <= ferr_evt | (ferr_r & ~(wr_ok & hit_ctl & pwdata[uart_core_pkg::CTL_FERR]));
      ovr_r  <= ovr_evt | (ovr_r & ~(wr_ok & hit_ctl & pwdata[uart_core_pkg::CTL_OVR]));
      tx_done_r <= tx_done_evt |
                   (tx_done_r & ~(wr_ok & hit_ctl & pwdata[uart_core_pkg::CTL_TX_DONE]));
      if (push)
        tx_hold_r <= pwdata[8:0];
      tx_full_r <= push | (tx_full_r & ~ch_restart[TXC]);
      if (rx_finish && !(rx_valid_r && !pop))
        rx_data_r <= rx_word;
      rx_valid_r <= (rx_finish & ~(rx_valid_r & ~pop)) | (rx_valid_r & ~pop);
    end
  end

  wire [31:0] ctl_rd = {20'h0,
                        rx_state_r != uart_core_pkg::RX_IDLE,
                        tx_state_r != uart_core_pkg::TX_IDLE,
                        tx_full_r, rx_valid_r, tx_done_r, ovr_r, ferr_r, perr_r,
                        1'b0, ir_en_r, ab_en_r, err_ie_r};
  wire [31:0] rd_mux = hit_cfg  ? cfg_r :
                       hit_mode ? mode_r :
                       hit_ctl  ? ctl_rd :
                       hit_baud ? {tx_div_r, rx_div_r} :
                       hit_data ? {23'h0, rx_data_r} : 32'h0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      prdata_r <= 32'h0;
    else if (clk_en && rd_setup)
      prdata_r <= rd_mux;
  end

  assign prdata         = prdata_r;
  assign pready         = clk_en;
  assign pslverr        = access & ~mapped;
  assign tx_line        = tx_line_r;
  assign rx_error_event = err_ie_r & (perr_r | ferr_r | ovr_r);

endmodule

/* shared/uart_core_pkg.sv */
// Register map, field layout, reset values and timing constants of the serial core
package uart_core_pkg;

  localparam logic [7:0] OFF_CONFIG  = 8'h00;
  localparam logic [7:0] OFF_MODE    = 8'h10;
  localparam logic [7:0] OFF_CONTROL = 8'h30;
  localparam logic [7:0] OFF_BAUD    = 8'h50;
  localparam logic [7:0] OFF_DATA    = 8'h70;

  // Frame settings: transmit half at bit 0, receive half at CFG_RX_BASE
  localparam int CFG_START    = 0;
  localparam int CFG_PAR_EN   = 1;
  localparam int CFG_PAR_MD   = 2;
  localparam int CFG_STOP_EN  = 4;
  localparam int CFG_STOP_LEN = 5;
  localparam int CFG_LEN      = 8;
  localparam int CFG_RX_BASE  = 16;
  localparam logic [31:0] CONFIG_MASK  = 32'h077f_077f;
  localparam logic [31:0] CONFIG_RESET = 32'h0331_0331;

  localparam int MD_FULL_SLOW = 0;
  localparam int MD_BAUD_SLOW = 1;
  localparam int MD_FORCE     = 2;
  localparam int MD_RX_SW     = 3;
  localparam int MD_TX_SW     = 4;
  localparam int MD_CLK_DIV   = 8;
  localparam logic [31:0] MODE_MASK  = 32'h0000_031f;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  localparam int CTL_ERR_IE   = 0;
  localparam int CTL_AB_EN    = 1;
  localparam int CTL_IR_EN    = 2;
  localparam int CTL_PERR     = 4;
  localparam int CTL_FERR     = 5;
  localparam int CTL_OVR      = 6;
  localparam int CTL_TX_DONE  = 7;
  localparam int CTL_RX_VALID = 8;
  localparam int CTL_TX_FULL  = 9;
  localparam int CTL_TX_BUSY  = 10;
  localparam int CTL_RX_BUSY  = 11;

  localparam int BAUD_TX_POS = 16;
  localparam logic [15:0] BAUD_RESET = 16'h0010;

  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;

  // Slow clock: phase accumulator adds two per bit (half-bit ticks), wraps at the clock rate
  localparam logic [16:0] SLOW_CLOCK_HZ = 17'h08000;
  localparam logic [15:0] HALF_INC_9600 = 16'h4b00;
  localparam logic [15:0] HALF_INC_4800 = 16'h2580;
  localparam logic [15:0] HALF_INC_2400 = 16'h12c0;
  localparam logic [15:0] HALF_INC_1200 = 16'h0960;
  localparam logic [1:0]  SEL_1200 = 2'h0;
  localparam logic [1:0]  SEL_9600 = 2'h1;
  localparam logic [1:0]  SEL_4800 = 2'h2;

  localparam int AB_SHIFT_NORMAL = 4;
  localparam int AB_SHIFT_IR     = 7;
  localparam logic [3:0] AB_LAST_EDGE = 4'h7;
  localparam logic [3:0] AB_FIRST_BIT = 4'h7;

  typedef enum logic [1:0] {PAR_ODD, PAR_EVEN, PAR_ONE, PAR_ZERO} parity_mode_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_DETECT, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

endpackage

/* sim/low_power_uart_core_properties.sv */
// Port-level assertions for the serial core
`timescale 1ns/100ps
module low_power_uart_core_properties #(
  parameter int ADDR_W = 8
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              clk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              tx_line,
  input wire logic              rx_error_event
);
  logic err_ie_r;
  logic rd_setup_r;
  wire  acc = psel && penable;
  wire  ctl_wr = acc && pready && pwrite && paddr[7:0] == uart_core_pkg::OFF_CONTROL;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Shadow of the error enable and of read setup cycles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_ie_r <= 1'b0;
      rd_setup_r <= 1'b0;
    end else begin
      rd_setup_r <= psel && !penable && !pwrite && clk_en;
      if (ctl_wr) begin
        err_ie_r <= pwdata[uart_core_pkg::CTL_ERR_IE];
      end
    end
  end
  pready_follow_a: assert property (pready == clk_en)
    else $error("pready differs from clk_en");
  err_in_access_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  unmapped_read_a: assert property (acc && !pwrite && paddr[7:0] == 8'h04 |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  rdata_hold_a: assert property (!rd_setup_r |-> $stable(prdata))
    else $error("prdata changed without read setup");
  err_gate_a: assert property (!err_ie_r |-> !rx_error_event)
    else $error("error event while disabled");
  idle_high_a: assert property ($fell(rst) |-> tx_line)
    else $error("tx_line not idle after reset");
  start_width_a: assert property ($fell(tx_line) |=> !tx_line)
    else $error("low bit shorter than two clocks");
  freeze_tx_a: assert property (!clk_en |=> $stable(tx_line))
    else $error("tx_line moved while frozen");
  tx_frame_c: cover property ($fell(tx_line));
  err_event_c: cover property ($rose(rx_error_event));
  refused_c: cover property (pslverr);
endmodule

/* sim/serial_peer_model.sv */
// Remote serial device: frames bytes onto rx_line and captures tx_line
`timescale 1ns/100ps
module serial_peer_model (
  input  wire logic        sys_clk,
  input  wire logic        tx_line,
  input  wire logic [31:0] bit_cyc,
  output logic             rx_line,
  output logic [7:0]       got,
  output int               got_cnt
);
  initial begin
    rx_line = 1'b1;
    got = 8'h00;
    got_cnt = 0;
  end
  always begin
    @(negedge tx_line);
    repeat (bit_cyc / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge sys_clk);
      got[i] = tx_line;
    end
    got_cnt++;
  end
  task automatic send(input logic [7:0] d, input logic stop_v);
    @(posedge sys_clk) rx_line <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      repeat (bit_cyc) @(posedge sys_clk);
      rx_line <= (i < 8) ? d[i] : stop_v;
    end
    repeat (bit_cyc) @(posedge sys_clk);
    rx_line <= 1'b1;
    repeat (2 * bit_cyc) @(posedge sys_clk);
  endtask
endmodule

/* sim/low_power_uart_core_tb_top.sv */
// Testbench for the serial core: APB master, remote peer and checks
`timescale 1ns/100ps
module low_power_uart_core_tb_top;
  logic        sys_clk, rst, clk_en, slow_timer_clock, psel, penable, pwrite;
  logic [7:0]  paddr, got;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, rx_line, tx_line, rx_error_event, serr;
  int          bit_cyc, got_cnt, err_total, total_checks, cyc;
  typedef struct {logic [1:0] div; logic [7:0] d;} tx_row_t;
  tx_row_t     rows [3] = '{'{uart_core_pkg::DIV_BY1, 8'ha5}, '{uart_core_pkg::DIV_BY2, 8'h3c},
                            '{uart_core_pkg::DIV_BY4, 8'h81}};
  low_power_uart_core u_low_power_uart_core (.sys_clk, .rst, .clk_en, .slow_timer_clock, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_line, .tx_line,
    .rx_error_event);
  serial_peer_model u_serial_peer_model (.sys_clk, .tx_line, .bit_cyc, .rx_line, .got, .got_cnt);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always #15259 slow_timer_clock = ~slow_timer_clock;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {rst, clk_en, psel, penable, pwrite, slow_timer_clock} = 6'b110000;
    paddr = 8'h00;
    pwdata = 32'h0;
    {bit_cyc, err_total, total_checks, cyc} = {32'd8, 32'd0, 32'd0, 32'd0};
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b1, uart_core_pkg::OFF_BAUD, 32'h0004_0004);
    // Bit time is two half bits of four module clocks
    foreach (rows[i]) begin
      bit_cyc = 8 << rows[i].div;
      apb(1'b1, uart_core_pkg::OFF_MODE, {22'h0, rows[i].div, 8'h00});
      apb(1'b1, uart_core_pkg::OFF_DATA, {24'h0, rows[i].d});
      wait (got_cnt == i + 1);
      chk("tx byte", {24'h0, rows[i].d}, {24'h0, got});
    end
    repeat (80) @(posedge sys_clk);
    bit_cyc = 8;
    apb(1'b1, uart_core_pkg::OFF_MODE, 32'h0);
    apb(1'b1, uart_core_pkg::OFF_CONTROL, 32'h1);
    u_serial_peer_model.send(8'hc3, 1'b1);
    apb(1'b0, uart_core_pkg::OFF_DATA, 32'h0);
    chk("rx byte", 32'hc3, q);
    u_serial_peer_model.send(8'h5a, 1'b0);
    apb(1'b0, uart_core_pkg::OFF_CONTROL, 32'h0);
    chk("frame flag", 32'h1, {31'h0, q[5]});
    chk("err event", 32'h1, {31'h0, rx_error_event});
    apb(1'b0, uart_core_pkg::OFF_DATA, 32'h0);
    apb(1'b1, uart_core_pkg::OFF_CONTROL, 32'h0);
    #1 chk("event masked", 32'h0, {31'h0, rx_error_event});
    // Receive even parity: a set parity bit after four ones is wrong
    apb(1'b1, uart_core_pkg::OFF_CONFIG, 32'h0337_0331);
    u_serial_peer_model.send(8'hc3, 1'b1);
    apb(1'b0, uart_core_pkg::OFF_CONTROL, 32'h0);
    chk("parity flag", 32'h1, {31'h0, q[4]});
    apb(1'b0, uart_core_pkg::OFF_DATA, 32'h0);
    chk("parity word", 32'hc3, q);
    apb(1'b1, uart_core_pkg::OFF_CONFIG, uart_core_pkg::CONFIG_RESET);
    apb(1'b1, uart_core_pkg::OFF_CONTROL, 32'h30);
    bit_cyc = 16;
    apb(1'b1, uart_core_pkg::OFF_BAUD, 32'h0004_0010);
    apb(1'b1, uart_core_pkg::OFF_CONTROL, 32'h2);
    u_serial_peer_model.send(8'h55, 1'b1);
    apb(1'b0, uart_core_pkg::OFF_BAUD, 32'h0);
    chk("ab divisor", (8 * 16) / 16, {16'h0, q[15:0]});
    apb(1'b0, uart_core_pkg::OFF_CONTROL, 32'h0);
    chk("ab enable", 32'h0, {31'h0, q[1]});
    apb(1'b0, uart_core_pkg::OFF_DATA, 32'h0);
    chk("ab word", 32'h55, q);
    clk_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
    clk_en <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, uart_core_pkg::OFF_CONFIG, 32'h0);
    chk("config reset", uart_core_pkg::CONFIG_RESET, q);
    apb(1'b0, uart_core_pkg::OFF_MODE, 32'h0);
    chk("mode reset", uart_core_pkg::MODE_RESET, q);
    apb(1'b0, 8'h04, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, serr});
    chk("unmapped data", 32'h0, q);
    test_done();
  end
endmodule
bind low_power_uart_core low_power_uart_core_properties #(.ADDR_W(ADDR_W))
  u_low_power_uart_core_properties (.sys_clk, .rst, .clk_en, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .tx_line, .rx_error_event);
